// ### mac_audio_port.sv
// Serial audio output port with clock generation and AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module mac_audio_port
    import mac_pkg::*;
#(
    parameter int FRAME_TICKS = 2 * MAC_FS_RATIO,
    parameter int CNT_W       = 10
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ref_clk_tick,
    input  wire logic        pll_clk_tick,
    input  wire logic [31:0] adc_sample,
    output logic             sample_taken,
    output logic [2:0]       filter_rate_sel,
    input  wire logic        bit_clock_i,
    output logic             bit_clock_o,
    output logic             bit_clock_oe,
    input  wire logic        sample_sync_i,
    output logic             sample_sync_o,
    output logic             sample_sync_oe,
    output logic             serial_out
);

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [9:0]       fmt_reg;
    logic [8:0]       ovr_reg;
    logic [8:0]       clk_reg;
    logic [8:0]       rate_reg;
    logic             aw_held_reg;
    logic             w_held_reg;
    logic [3:0]       aw_idx_reg;
    logic [31:0]      w_data_reg;
    logic [3:0]       w_strb_reg;
    logic [31:0]      status;
    logic [31:0]      rd_word;
    logic             rd_hit;
    logic             wr_hit;
    logic             do_write;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        for (int i = 0; i < 4; i++) begin
            lane_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
        end
    endfunction : lane_merge

    function automatic logic map_hit(input logic [3:0] idx);
        map_hit = (idx >= MAC_IDX_SERIAL_FORMAT) && (idx <= MAC_IDX_STATUS);
    endfunction : map_hit

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_idx_reg  <= 4'h0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_idx_reg  <= s_axi_awaddr[5:2];
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    assign wr_hit = map_hit(aw_idx_reg) && (aw_idx_reg != MAC_IDX_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= MAC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? MAC_RESP_OKAY : MAC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fmt_reg  <= MAC_RST_SERIAL_FORMAT;
            ovr_reg  <= MAC_RST_WORD_OVERRIDE;
            clk_reg  <= MAC_RST_CLOCK_GEN;
            rate_reg <= MAC_RST_RATE;
        end else if (do_write) begin
            unique case (aw_idx_reg)
                MAC_IDX_SERIAL_FORMAT:
                    fmt_reg <= lane_merge({22'h0, fmt_reg}, w_data_reg, w_strb_reg)[9:0];
                MAC_IDX_WORD_OVERRIDE:
                    ovr_reg <= lane_merge({23'h0, ovr_reg}, w_data_reg, w_strb_reg)[8:0];
                MAC_IDX_CLOCK_GEN:
                    clk_reg <= lane_merge({23'h0, clk_reg}, w_data_reg, w_strb_reg)[8:0];
                MAC_IDX_RATE:
                    rate_reg <= lane_merge({23'h0, rate_reg}, w_data_reg, w_strb_reg)[8:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_hit = map_hit(s_axi_araddr[5:2]);
        unique case (s_axi_araddr[5:2])
            MAC_IDX_SERIAL_FORMAT: rd_word = {22'h0, fmt_reg};
            MAC_IDX_WORD_OVERRIDE: rd_word = {23'h0, ovr_reg};
            MAC_IDX_CLOCK_GEN:     rd_word = {23'h0, clk_reg};
            MAC_IDX_RATE:          rd_word = {23'h0, rate_reg};
            MAC_IDX_STATUS:        rd_word = status;
            default:               rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= MAC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? MAC_RESP_OKAY : MAC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control decode
    // ----------------------------------------------------------------
    logic       master;
    logic [1:0] fmt;
    logic       is_dsp;
    logic [5:0] word_len;

    assign master = clk_reg[MAC_BIT_MASTER];
    assign fmt    = fmt_reg[MAC_POS_FORMAT +: 2];
    assign is_dsp = (fmt == MAC_FMT_DSP);

    always_comb begin
        unique case (fmt_reg[MAC_POS_WORD_SIZE +: 2])
            2'h0: word_len = MAC_LEN_16;
            2'h1: word_len = MAC_LEN_20;
            2'h2: word_len = MAC_LEN_24;
            2'h3: word_len = (fmt == MAC_FMT_RJ) ? MAC_LEN_24 : MAC_LEN_32;
        endcase
        if (ovr_reg[MAC_BIT_BYTE_FORCE]) begin
            word_len = MAC_LEN_8;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filter_rate_sel <= 3'h0;
        end else begin
            filter_rate_sel <= rate_reg[MAC_POS_RATE +: 3];
        end
    end

    // ----------------------------------------------------------------
    // Core clock and master generator
    // ----------------------------------------------------------------
    logic                   src_tick;
    logic                   core_tick;
    logic [CNT_W-1:0]       fcnt_reg;
    logic [5:0]             bcnt_reg;
    logic                   bgen_reg;
    logic                   sgen_reg;
    logic [5:0]             bdiv;
    logic                   frame_wrap;

    assign src_tick = clk_reg[MAC_BIT_CLK_SOURCE] ? pll_clk_tick : ref_clk_tick;

    mac_tick_div u_core_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .src_tick (src_tick),
        .div_code (clk_reg[MAC_POS_CORE_DIV +: 3]),
        .tick_out (core_tick)
    );

    // Ticks per bit clock half period, reserved codes act as 32
    function automatic logic [5:0] bclk_half(input logic [2:0] code);
        bclk_half = (code > 3'h5) ? 6'h20 : 6'(6'h01 << code);
    endfunction : bclk_half

    assign bdiv       = bclk_half(clk_reg[MAC_POS_BCLK_DIV +: 3]);
    assign frame_wrap = (fcnt_reg == CNT_W'(FRAME_TICKS - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fcnt_reg <= '0;
            bcnt_reg <= 6'h00;
            bgen_reg <= 1'b0;
            sgen_reg <= 1'b0;
        end else if (core_tick) begin
            fcnt_reg <= frame_wrap ? '0 : fcnt_reg + 1'b1;
            if (frame_wrap) begin
                bcnt_reg <= 6'h00;
                bgen_reg <= 1'b0;
                sgen_reg <= (fmt != MAC_FMT_I2S);
            end else begin
                if (fcnt_reg == CNT_W'(FRAME_TICKS / 2 - 1)) begin
                    sgen_reg <= ~sgen_reg;
                end
                if (bcnt_reg == bdiv - 6'h01) begin
                    bcnt_reg <= 6'h00;
                    bgen_reg <= ~bgen_reg;
                end else begin
                    bcnt_reg <= bcnt_reg + 6'h01;
                end
            end
        end
    end

    logic sync_inv;
    assign sync_inv = fmt_reg[MAC_BIT_SYNC_POL] && !is_dsp;

    assign bit_clock_o    = bgen_reg ^ fmt_reg[MAC_BIT_BCLK_INV];
    assign sample_sync_o  = sgen_reg ^ sync_inv;
    assign bit_clock_oe   = master;
    assign sample_sync_oe = master;

    // ----------------------------------------------------------------
    // Serial framing
    // ----------------------------------------------------------------
    logic                   b_now;
    logic                   s_now;
    logic                   b_prev_reg;
    logic                   s_prev_reg;
    logic                   rise;
    logic                   fall;
    logic                   restart;
    logic                   left_phase;
    logic [CNT_W-1:0]       cnt_reg;
    logic [CNT_W-1:0]       half_reg;
    logic [CNT_W-1:0]       k;
    logic [CNT_W-1:0]       off;
    logic [CNT_W-1:0]       j;
    logic [31:0]            word_reg;
    logic [31:0]            cur_word;
    logic [31:0]            left_word;
    logic [31:0]            right_word;
    logic                   in_left;
    logic                   next_bit;

    // Internal levels in normal polarity
    assign b_now = (master ? bgen_reg : bit_clock_i ^ fmt_reg[MAC_BIT_BCLK_INV]);
    assign s_now = (master ? sgen_reg : sample_sync_i ^ sync_inv);
    assign rise  = b_now && !b_prev_reg;
    assign fall  = !b_now && b_prev_reg;
    assign left_phase = (fmt == MAC_FMT_I2S) ? !s_now : s_now;
    assign restart    = (s_now ^ s_prev_reg) && (!is_dsp || s_now);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_prev_reg <= 1'b0;
            s_prev_reg <= 1'b0;
        end else begin
            b_prev_reg <= b_now;
            s_prev_reg <= s_now;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg  <= '0;
            half_reg <= '0;
        end else if (restart) begin
            cnt_reg  <= '0;
            half_reg <= cnt_reg;
        end else if (rise) begin
            cnt_reg  <= cnt_reg + 1'b1;
        end
    end

    // Sample taken at the start of each frame
    assign cur_word = (restart && (left_phase || is_dsp)) ? adc_sample : word_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_reg     <= 32'h00000000;
            sample_taken <= 1'b0;
        end else begin
            sample_taken <= restart && (left_phase || is_dsp);
            if (restart && (left_phase || is_dsp)) begin
                word_reg <= adc_sample;
            end
        end
    end

    assign left_word  = (!fmt_reg[MAC_BIT_PHASE_SWAP] || fmt_reg[MAC_BIT_MONO_DUP])
                        ? cur_word : 32'h00000000;
    assign right_word = (fmt_reg[MAC_BIT_PHASE_SWAP] || fmt_reg[MAC_BIT_MONO_DUP])
                        ? cur_word : 32'h00000000;

    // Index of the coming rising edge and position in the slot
    always_comb begin
        k = restart ? CNT_W'(1) : cnt_reg + 1'b1;
        unique case (fmt)
            MAC_FMT_LJ:  off = CNT_W'(1);
            MAC_FMT_I2S: off = CNT_W'(2);
            MAC_FMT_RJ:  off = half_reg - CNT_W'(word_len) + 1'b1;
            MAC_FMT_DSP: off = fmt_reg[MAC_BIT_SYNC_POL] ? CNT_W'(1) : CNT_W'(2);
        endcase
        j        = k - off;
        in_left  = is_dsp ? (j < CNT_W'(word_len)) : left_phase;
        if (is_dsp && !in_left) begin
            j = j - CNT_W'(word_len);
        end
        if (k < off || j >= CNT_W'(word_len)) begin
            next_bit = 1'b0;
        end else if (in_left) begin
            next_bit = left_word[5'(31 - j[4:0])];
        end else begin
            next_bit = right_word[5'(31 - j[4:0])];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_out <= 1'b0;
        end else if (restart || fall) begin
            serial_out <= next_bit;
        end
    end

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    assign status = {14'h0, half_reg, word_len, master, left_phase};

endmodule : mac_audio_port

// ### mac_audio_port_monitor.sv
// Port-level checker for the audio port block
`timescale 1ns/10ps
module mac_audio_port_mon (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        sample_taken,
    input wire logic        bit_clock_i,
    input wire logic        bit_clock_oe,
    input wire logic        sample_sync_oe,
    input wire logic        serial_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence seq_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence seq_quiet;
        $stable(serial_out) [*3];
    endsequence
    AST_PIN_DIR: assert property (bit_clock_oe == sample_sync_oe)
        else $error("clock pin enables disagree");
    AST_DATA_QUIET: assert property (!bit_clock_oe && $rose(bit_clock_i) |=> seq_quiet)
        else $error("serial data moved near bit clock rise");
    AST_B_LAT: assert property (seq_wr_taken |=> ##[0:2] s_axi_bvalid)
        else $error("write response late");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during read answer");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    AST_TAKEN_PULSE: assert property (sample_taken |=> !sample_taken)
        else $error("sample pulse too long");
endmodule : mac_audio_port_mon

bind mac_audio_port mac_audio_port_mon mac_audio_port_mon_i (.*);

// ### mac_host_model.sv
// Receiving host model: supplies slave clocks and captures words
`timescale 1ns/10ps
module mac_host_model (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   run,
    input  wire logic   sdata,
    output logic        bclk,
    output logic        sync,
    output logic [31:0] word,
    output logic        word_hi,
    output logic        word_vld
);
    logic [2:0]  div_reg;
    logic [5:0]  bit_reg;
    logic [31:0] sh_reg;
    logic        rise;
    assign rise = (div_reg == 3'h3);
    // Clocks stand low while idle; 32 bit clocks per half
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            div_reg <= 3'h0;
            bit_reg <= 6'h0;
            bclk    <= 1'b0;
            sync    <= 1'b0;
        end else begin
            div_reg <= div_reg + 3'h1;
            if (rise) begin
                bclk <= 1'b1;
            end
            if (div_reg == 3'h7) begin
                bclk    <= 1'b0;
                bit_reg <= bit_reg + 6'h1;
                sync    <= (bit_reg + 6'h1) < 6'h20;
            end
        end
    end
    // Sample data on each rise, report each half
    always_ff @(posedge aclk) begin
        word_vld <= 1'b0;
        if (aresetn && run && rise) begin
            sh_reg <= {sh_reg[30:0], sdata};
            if (bit_reg[4:0] == 5'h1f) begin
                word     <= {sh_reg[30:0], sdata};
                word_hi  <= sync;
                word_vld <= 1'b1;
            end
        end
    end
endmodule : mac_host_model

// ### mac_pkg.sv
// Constants for the mono ADC audio port and clock generation block
package mac_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [3:0] MAC_IDX_SERIAL_FORMAT = 4'h4;
    localparam logic [3:0] MAC_IDX_WORD_OVERRIDE = 4'h5;
    localparam logic [3:0] MAC_IDX_CLOCK_GEN     = 4'h6;
    localparam logic [3:0] MAC_IDX_RATE          = 4'h7;
    localparam logic [3:0] MAC_IDX_STATUS        = 4'h8;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [9:0] MAC_RST_SERIAL_FORMAT = 10'h050;
    localparam logic [8:0] MAC_RST_WORD_OVERRIDE = 9'h000;
    localparam logic [8:0] MAC_RST_CLOCK_GEN     = 9'h140;
    localparam logic [8:0] MAC_RST_RATE          = 9'h000;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int MAC_BIT_MONO_DUP      = 9;
    localparam int MAC_BIT_BCLK_INV      = 8;
    localparam int MAC_BIT_SYNC_POL      = 7;
    localparam int MAC_POS_WORD_SIZE     = 5;
    localparam int MAC_POS_FORMAT        = 3;
    localparam int MAC_BIT_PHASE_SWAP    = 1;
    localparam int MAC_BIT_BYTE_FORCE    = 5;
    localparam int MAC_BIT_CLK_SOURCE    = 8;
    localparam int MAC_POS_CORE_DIV      = 5;
    localparam int MAC_POS_BCLK_DIV      = 2;
    localparam int MAC_BIT_MASTER        = 0;
    localparam int MAC_POS_RATE          = 1;

    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    localparam logic [1:0] MAC_FMT_RJ  = 2'h0;
    localparam logic [1:0] MAC_FMT_LJ  = 2'h1;
    localparam logic [1:0] MAC_FMT_I2S = 2'h2;
    localparam logic [1:0] MAC_FMT_DSP = 2'h3;

    localparam logic [5:0] MAC_LEN_8  = 6'h08;
    localparam logic [5:0] MAC_LEN_16 = 6'h10;
    localparam logic [5:0] MAC_LEN_20 = 6'h14;
    localparam logic [5:0] MAC_LEN_24 = 6'h18;
    localparam logic [5:0] MAC_LEN_32 = 6'h20;

    // Master clock periods per sample
    localparam int MAC_FS_RATIO = 256;

    localparam logic [1:0] MAC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] MAC_RESP_SLVERR = 2'h2;

endpackage : mac_pkg

// ### mac_tick_div.sv
// Fractional divider of core clock edge ticks (1, 1.5, 2 ... 12)
`timescale 1ns/10ps
module mac_tick_div
    import mac_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       src_tick,
    input  wire logic [2:0] div_code,
    output logic            tick_out
);

    logic [5:0] acc_reg;
    logic [5:0] sum;
    logic [5:0] limit;

    // Divide ratio in half units
    function automatic logic [5:0] half_units(input logic [2:0] code);
        unique case (code)
            3'h0: half_units = 6'h02;
            3'h1: half_units = 6'h03;
            3'h2: half_units = 6'h04;
            3'h3: half_units = 6'h06;
            3'h4: half_units = 6'h08;
            3'h5: half_units = 6'h0c;
            3'h6: half_units = 6'h10;
            3'h7: half_units = 6'h18;
        endcase
    endfunction : half_units

    assign limit = half_units(div_code);
    assign sum   = acc_reg + 6'h02;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_reg  <= 6'h00;
            tick_out <= 1'b0;
        end else if (src_tick) begin
            if (sum >= limit) begin
                acc_reg  <= sum - limit;
                tick_out <= 1'b1;
            end else begin
                acc_reg  <= sum;
                tick_out <= 1'b0;
            end
        end else begin
            tick_out <= 1'b0;
        end
    end

endmodule : mac_tick_div

// ### tb_top.sv
// Self-checking bench for the audio port block
`timescale 1ns/10ps
module tb_top
    import mac_pkg::*;
();
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, ref_clk_tick = 1, pll_clk_tick = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        sample_taken, bit_clock_i, bit_clock_o, bit_clock_oe, sample_sync_i;
    logic        sample_sync_o, sample_sync_oe, serial_out, host_bclk, host_sync;
    logic        run = 0, b_prev = 0, word_hi, word_vld;
    logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  filter_rate_sel;
    logic [31:0] s_axi_wdata = 0, adc_sample = 0, s_axi_rdata, word, s, hi[4], lo[4];
    logic [31:0] cfg[4] = '{32'h08, 32'h52, 32'h260, 32'h6a};
    logic [33:0] rd_q[$], b_q[$], w_q[$];
    int          error_cnt = 0, samples_checked = 0, cyc = 0, t_rise = 0, per = 0, rises = 0;
    int          n, r;

    mac_audio_port #(.FRAME_TICKS(64)) mac_audio_port_i (.*);
    mac_host_model mac_host_model_i (.aclk(aclk), .aresetn(aresetn), .run(run),
        .sdata(serial_out), .bclk(host_bclk), .sync(host_sync), .word(word),
        .word_hi(word_hi), .word_vld(word_vld));
    assign bit_clock_i   = bit_clock_oe ? bit_clock_o : host_bclk;
    assign sample_sync_i = sample_sync_oe ? sample_sync_o : host_sync;

    always #20 aclk = ~aclk;

    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic tmo;
        error_cnt++;
        conclude();
    endtask : tmo

    task automatic cmp_bus(input logic [33:0] g, input logic [33:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp_bus

    task automatic cmp_pin(input logic [33:0] g, input logic [33:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp_pin

    // Write (w=1) or read; e holds expected response and read data
    task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d,
                       input logic [33:0] e);
        logic [4:0] t;
        @(posedge aclk);
        if (w) begin
            b_q.push_back(e);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            rd_q.push_back(e);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        for (int i = 0; i < 200; i++) begin
            @(negedge aclk);
            t = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
                 s_axi_bvalid & s_axi_bready, s_axi_arvalid & s_axi_arready,
                 s_axi_rvalid & s_axi_rready};
            @(posedge aclk);
            if (t[4]) s_axi_awvalid <= 1'b0;
            if (t[3]) s_axi_wvalid <= 1'b0;
            if (t[2]) s_axi_bready <= 1'b0;
            if (t[1]) s_axi_arvalid <= 1'b0;
            if (t[0]) s_axi_rready <= 1'b0;
            if (t[2] | t[0]) return;
        end
        tmo();
    endtask : bus

    // Result watcher and bit clock period meter
    always @(negedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) cmp_bus({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
        if (s_axi_bvalid && s_axi_bready) cmp_bus({s_axi_bresp, 32'h0}, b_q.pop_front());
        if (word_vld && w_q.size() > 0) cmp_pin({1'b0, word_hi, word}, w_q.pop_front());
        if (bit_clock_o && !b_prev) begin
            per = cyc - t_rise;
            t_rise = cyc;
            rises++;
        end
        b_prev = bit_clock_o;
        cyc++;
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        void'($urandom(14));
        s = $urandom;
        adc_sample <= s;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        run <= 1'b1;
        bus(0, 6'h10, 0, {2'h0, 32'h050});
        bus(0, 6'h14, 0, 34'h0);
        bus(0, 6'h18, 0, {2'h0, 32'h140});
        bus(0, 6'h1c, 0, 34'h0);
        bus(0, 6'h24, 0, {MAC_RESP_SLVERR, 32'h0});
        bus(1, 6'h28, 32'h1, {MAC_RESP_SLVERR, 32'h0});
        for (int c = 0; c < 8; c++) begin
            bus(1, 6'h1c, c << 1, 34'h0);
            bus(0, 6'h1c, 0, c << 1);
            cmp_pin(filter_rate_sel, c);
        end
        cmp_pin(bit_clock_oe, 0);
        hi = '{{s[31:16], 16'h0}, {1'b0, s[31:8], 7'h0}, {8'h0, s[31:8]}, 32'h0};
        lo = '{32'h0, 32'h0, {8'h0, s[31:8]}, {s[31:24], 24'h0}};
        for (int i = 0; i < 4; i++) begin
            bus(1, 6'h14, {26'h0, i == 3, 5'h0}, 34'h0);
            bus(1, 6'h10, cfg[i], 34'h0);
            repeat (1100) @(posedge aclk);
            for (n = 0; n < 700 && !(word_vld && !word_hi); n++) @(negedge aclk);
            if (n == 700) tmo();
            @(posedge aclk);
            w_q.push_back({2'h1, hi[i]});
            w_q.push_back({2'h0, lo[i]});
            for (n = 0; n < 700 && w_q.size() > 0; n++) @(negedge aclk);
            if (n == 700) tmo();
        end
        run <= 1'b0;
        for (int c = 0; c < 6; c++) begin
            bus(1, 6'h18, (c << 2) | 1, 34'h0);
            repeat (300) @(posedge aclk);
            cmp_pin(per, 2 << c);
        end
        cmp_pin(bit_clock_oe, 1);
        for (int c = 0; c < 4; c++) begin
            bus(1, 6'h18, (c << 6) | 1, 34'h0);
            repeat (300) @(posedge aclk);
            cmp_pin(per, 2 << c);
        end
        bus(1, 6'h18, 32'h101, 34'h0);
        r = rises;
        repeat (300) @(posedge aclk);
        cmp_pin(rises - r, 0);
        pll_clk_tick <= 1'b1;
        repeat (300) @(posedge aclk);
        cmp_pin(per, 2);
        conclude();
    end
endmodule : tb_top
